// >>> core/pfc_bus_cycle.sv
`timescale 1ns/1ps
`include "pfc_regs.svh"
// One bus cycle on the flash pins: a write strobe or a read with sampling.
module pfc_bus_cycle
    import pfc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic        start,
    input  wire logic        is_write,
    input  wire logic [17:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic [7:0]  data_in,
    output logic             busy,
    output logic             done,
    output logic [7:0]       rdata,
    output pfc_pins_s        pins
);
    typedef enum logic [3:0] {
        PFC_BC_IDLE   = 4'h1,
        PFC_BC_SETUP  = 4'h2,
        PFC_BC_STROBE = 4'h4,
        PFC_BC_HOLD   = 4'h8
    } pfc_bc_e;

    pfc_bc_e    state;
    logic [7:0] cnt;
    logic       wr;
    logic [7:0] sync1;
    logic [7:0] sync2;

    assign busy = (state != PFC_BC_IDLE);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
        end else if (clk_en) begin
            sync1 <= data_in;
            sync2 <= sync1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= PFC_BC_IDLE;
            cnt   <= 8'h00;
            wr    <= 1'b0;
            done  <= 1'b0;
            rdata <= 8'h00;
            pins  <= '{addr: 18'h00000, data_out: 8'h00, data_oe: 1'b0,
                       cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
        end else if (clk_en) begin
            done <= 1'b0;
            unique case (state)
                PFC_BC_IDLE: begin
                    if (start) begin
                        wr            <= is_write;
                        pins.addr     <= addr;
                        pins.data_out <= wdata;
                        pins.data_oe  <= is_write;
                        cnt           <= 8'(`PFC_SETUP_CYC);
                        state         <= PFC_BC_SETUP;
                    end
                end
                PFC_BC_SETUP: begin
                    if (cnt > 8'h01) begin
                        cnt <= cnt - 8'h01;
                    end else begin
                        pins.cs_n <= 1'b0;
                        pins.we_n <= ~wr;
                        pins.oe_n <= wr;
                        cnt   <= wr ? 8'(`PFC_STROBE_CYC)
                                    : 8'(`PFC_READ_CYC + 2);
                        state <= PFC_BC_STROBE;
                    end
                end
                PFC_BC_STROBE: begin
                    if (cnt > 8'h01) begin
                        cnt <= cnt - 8'h01;
                    end else begin
                        pins.cs_n <= 1'b1;
                        pins.we_n <= 1'b1;
                        pins.oe_n <= 1'b1;
                        rdata     <= sync2;
                        state     <= PFC_BC_HOLD;
                    end
                end
                PFC_BC_HOLD: begin
                    pins.data_oe <= 1'b0;
                    done         <= 1'b1;
                    state        <= PFC_BC_IDLE;
                end
                default: state <= PFC_BC_IDLE;
            endcase
        end
    end
endmodule

// >>> core/pfc_flash_ctrl.sv
`timescale 1ns/1ps
`include "pfc_regs.svh"
// Function
// - Chip erase uses six unlock cycles ending 10 to 5555.
// - Byte program is AA, 55, A0, then address and data.
// - Address taken at later falling edge, data at earlier rising.
// - Lockout uses the erase prefix ending 40 to 5555.
// - Identification entered with the 90 sequence, left with one F0 write.
module pfc_flash_ctrl
    import pfc_pkg::*;
#(
    parameter int unsigned BP_CYCLES = `PFC_BP_CYC,
    parameter int unsigned EC_CYCLES = `PFC_EC_CYC
)(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire pfc_req_s    req,
    output logic             rsp_valid,
    output logic [7:0]       rsp_data,
    output logic             rsp_timeout,
    output logic             op_busy,
    output logic [17:0]      flash_addr,
    output logic             flash_cs_n,
    output logic             flash_oe_n,
    output logic             flash_we_n,
    input  wire logic [7:0]  flash_data_in,
    output logic [7:0]       flash_data_out,
    output logic             flash_data_oe
);
    typedef enum logic [5:0] {
        PFC_S_IDLE  = 6'h01,
        PFC_S_CMD   = 6'h02,
        PFC_S_WAIT  = 6'h04,
        PFC_S_POLL  = 6'h08,
        PFC_S_READ  = 6'h10,
        PFC_S_DONE  = 6'h20
    } pfc_st_e;

    pfc_st_e     state;
    pfc_req_s    cur;
    logic [2:0]  step;
    logic [2:0]  last_step;
    logic [31:0] wait_cnt;
    logic [7:0]  prev_read;
    logic        have_prev;
    logic        bc_start;
    logic        bc_write;
    logic [17:0] bc_addr;
    logic [7:0]  bc_wdata;
    logic        bc_busy;
    logic        bc_done;
    logic [7:0]  bc_rdata;
    pfc_pins_s   pins;

    // Address and data of unlock cycle n for the current operation
    function automatic logic [25:0] cmd_cycle(input pfc_req_s r,
                                              input logic [2:0] n);
        logic [7:0] last;
        last = `PFC_CMD_PROGRAM;
        unique case (r.op)
            PFC_OP_ERASE:   last = `PFC_CMD_ERASE;
            PFC_OP_LOCK:    last = `PFC_CMD_LOCK;
            PFC_OP_ID_READ: last = `PFC_CMD_ID_ENTRY;
            default:        last = `PFC_CMD_PROGRAM;
        endcase
        unique case (n)
            3'd0, 3'd3: cmd_cycle = {`PFC_UNLOCK_ADDR1, `PFC_UNLOCK_DATA1};
            3'd1, 3'd4: cmd_cycle = {`PFC_UNLOCK_ADDR2, `PFC_UNLOCK_DATA2};
            3'd2: cmd_cycle = {`PFC_UNLOCK_ADDR1,
                               (r.op == PFC_OP_ERASE || r.op == PFC_OP_LOCK)
                               ? `PFC_CMD_SETUP : last};
            3'd5: cmd_cycle = {`PFC_UNLOCK_ADDR1, last};
            3'd6: cmd_cycle = {r.addr, r.data};
            default: cmd_cycle = {r.addr, `PFC_CMD_ID_EXIT};
        endcase
    endfunction

    assign req_ready = (state == PFC_S_IDLE);
    assign op_busy   = (state != PFC_S_IDLE);

    always_comb begin
        flash_addr     = pins.addr;
        flash_cs_n     = pins.cs_n;
        flash_oe_n     = pins.oe_n;
        flash_we_n     = pins.we_n;
        flash_data_out = pins.data_out;
        flash_data_oe  = pins.data_oe;
    end

    always_comb begin
        bc_start = 1'b0;
        bc_write = 1'b0;
        bc_addr  = cur.addr;
        bc_wdata = 8'h00;
        if (!bc_busy && !bc_done) begin
            unique case (state)
                PFC_S_CMD: begin
                    bc_start = 1'b1;
                    bc_write = 1'b1;
                    {bc_addr, bc_wdata} = cmd_cycle(cur, step);
                end
                PFC_S_POLL, PFC_S_READ: bc_start = 1'b1;
                default: bc_start = 1'b0;
            endcase
        end
    end

    pfc_bus_cycle u_cycle (
        .core_clk (core_clk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .start    (bc_start),
        .is_write (bc_write),
        .addr     (bc_addr),
        .wdata    (bc_wdata),
        .data_in  (flash_data_in),
        .busy     (bc_busy),
        .done     (bc_done),
        .rdata    (bc_rdata),
        .pins     (pins)
    );

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state       <= PFC_S_IDLE;
            cur         <= '{op: PFC_OP_READ, addr: 18'h00000, data: 8'h00};
            step        <= 3'd0;
            last_step   <= 3'd0;
            wait_cnt    <= 32'h00000000;
            prev_read   <= 8'h00;
            have_prev   <= 1'b0;
            rsp_valid   <= 1'b0;
            rsp_data    <= 8'h00;
            rsp_timeout <= 1'b0;
        end else if (clk_en) begin
            rsp_valid <= 1'b0;
            unique case (state)
                PFC_S_IDLE: begin
                    if (req_valid) begin
                        cur       <= req;
                        step      <= 3'd0;
                        have_prev <= 1'b0;
                        unique case (req.op)
                            PFC_OP_READ: begin
                                state <= PFC_S_READ;
                            end
                            PFC_OP_PROGRAM: begin
                                last_step <= 3'd3;
                                state     <= PFC_S_CMD;
                            end
                            PFC_OP_ERASE, PFC_OP_LOCK: begin
                                last_step <= 3'd5;
                                state     <= PFC_S_CMD;
                            end
                            PFC_OP_ID_READ: begin
                                last_step <= 3'd2;
                                state     <= PFC_S_CMD;
                            end
                            default: state <= PFC_S_IDLE;
                        endcase
                    end
                end
                PFC_S_CMD: begin
                    if (bc_done) begin
                        if (step == last_step) begin
                            wait_cnt <= (cur.op == PFC_OP_ERASE)
                                        ? EC_CYCLES : BP_CYCLES;
                            state    <= (cur.op == PFC_OP_ID_READ)
                                        ? PFC_S_READ : PFC_S_POLL;
                        end else if (step == 3'd2 &&
                                     cur.op == PFC_OP_PROGRAM) begin
                            step <= 3'd6;
                        end else if (step == 3'd7) begin
                            rsp_valid <= 1'b1;
                            state     <= PFC_S_IDLE;
                        end else begin
                            step <= step + 3'd1;
                        end
                        if (step == 3'd2 && cur.op == PFC_OP_PROGRAM)
                            last_step <= 3'd6;
                    end
                end
                PFC_S_POLL: begin
                    if (bc_done) begin
                        have_prev <= 1'b1;
                        prev_read <= bc_rdata;
                        if (have_prev &&
                            bc_rdata[`PFC_TOGGLE_BIT] ==
                            prev_read[`PFC_TOGGLE_BIT]) begin
                            rsp_data    <= bc_rdata;
                            rsp_timeout <= (cur.op == PFC_OP_PROGRAM) &&
                                (bc_rdata[`PFC_POLL_BIT] !=
                                 cur.data[`PFC_POLL_BIT]);
                            rsp_valid   <= 1'b1;
                            state       <= PFC_S_IDLE;
                        end else if (wait_cnt == 32'h00000000) begin
                            rsp_data    <= bc_rdata;
                            rsp_timeout <= 1'b1;
                            rsp_valid   <= 1'b1;
                            state       <= PFC_S_IDLE;
                        end
                    end
                    if (wait_cnt != 32'h00000000)
                        wait_cnt <= wait_cnt - 32'h00000001;
                end
                PFC_S_READ: begin
                    if (bc_done) begin
                        rsp_data    <= bc_rdata;
                        rsp_timeout <= 1'b0;
                        if (cur.op == PFC_OP_ID_READ) begin
                            step  <= 3'd7;
                            state <= PFC_S_CMD;
                        end else begin
                            rsp_valid <= 1'b1;
                            state     <= PFC_S_IDLE;
                        end
                    end
                end
                default: state <= PFC_S_IDLE;
            endcase
        end
    end
endmodule

// >>> core/pfc_pkg.sv
package pfc_pkg;
    typedef enum logic [4:0] {
        PFC_OP_READ    = 5'h01,
        PFC_OP_PROGRAM = 5'h02,
        PFC_OP_ERASE   = 5'h04,
        PFC_OP_LOCK    = 5'h08,
        PFC_OP_ID_READ = 5'h10
    } pfc_op_e;

    typedef struct packed {
        pfc_op_e     op;
        logic [17:0] addr;
        logic [7:0]  data;
    } pfc_req_s;

    typedef struct packed {
        logic [17:0] addr;
        logic [7:0]  data_out;
        logic        data_oe;
        logic        cs_n;
        logic        oe_n;
        logic        we_n;
    } pfc_pins_s;
endpackage

// >>> core/pfc_regs.svh
`ifndef PFC_REGS_SVH
`define PFC_REGS_SVH

`define PFC_ADDR_W         18
`define PFC_DATA_W         8
`define PFC_UNLOCK_ADDR1   18'h05555
`define PFC_UNLOCK_ADDR2   18'h02AAA
`define PFC_UNLOCK_DATA1   8'hAA
`define PFC_UNLOCK_DATA2   8'h55
`define PFC_CMD_SETUP      8'h80
`define PFC_CMD_ERASE      8'h10
`define PFC_CMD_LOCK       8'h40
`define PFC_CMD_PROGRAM    8'hA0
`define PFC_CMD_ID_ENTRY   8'h90
`define PFC_CMD_ID_EXIT    8'hF0
`define PFC_ID_MFR_ADDR    18'h00000
`define PFC_ID_DEV_ADDR    18'h00001
`define PFC_ID_LOCK_ADDR   18'h00002
`define PFC_BOOT_LAST      18'h01FFF
`define PFC_POLL_BIT       7
`define PFC_TOGGLE_BIT     6
`define PFC_LOCK_BIT       0
`define PFC_CLK_NS         100
`define PFC_SETUP_NS       100
`define PFC_SETUP_CYC      ((`PFC_SETUP_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_STROBE_NS      200
`define PFC_STROBE_CYC     ((`PFC_STROBE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_READ_NS        200
`define PFC_READ_CYC       ((`PFC_READ_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_BP_TIME_US     50
`define PFC_BP_CYC         (`PFC_BP_TIME_US * 1000 / `PFC_CLK_NS)
`define PFC_EC_TIME_MS     20000
`define PFC_EC_CYC         (`PFC_EC_TIME_MS * 10000)

`endif

// >>> tb/pfc_flash_ctrl_asserts.sv
`timescale 1ns/1ps
`include "pfc_regs.svh"
module pfc_flash_ctrl_asserts
    import pfc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic        req_valid,
    input  wire logic        req_ready,
    input  wire pfc_req_s    req,
    input  wire logic        rsp_valid,
    input  wire logic        op_busy,
    input  wire logic [17:0] flash_addr,
    input  wire logic        flash_cs_n,
    input  wire logic        flash_oe_n,
    input  wire logic        flash_we_n,
    input  wire logic [7:0]  flash_data_out,
    input  wire logic        flash_data_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire taken = req_valid && req_ready && clk_en;

    AST_WE_OE_EXCL: assert property (
        flash_we_n || flash_oe_n)
        else $error("Write and output strobes low together");
    AST_WE_NEEDS_CS: assert property (
        !flash_we_n |-> !flash_cs_n)
        else $error("Write strobe low without chip select");
    AST_NO_READ_DRIVE: assert property (
        !flash_oe_n |-> !flash_data_oe)
        else $error("Host drives data during a read");
    AST_WE_WIDTH: assert property (
        $fell(flash_we_n) |-> ##1 !flash_we_n ##1 flash_we_n)
        else $error("Write strobe not two cycles wide");
    AST_WE_SETUP: assert property (
        $fell(flash_we_n) |-> $stable(flash_addr) && $past(flash_data_oe))
        else $error("Address or data not set up before strobe");
    AST_WE_STABLE: assert property (
        !flash_we_n |=> $stable(flash_addr) && $stable(flash_data_out))
        else $error("Address or data moved under write strobe");
    AST_DATA_HOLD: assert property (
        $rose(flash_we_n) |-> flash_data_oe)
        else $error("Data released at strobe rise");
    AST_CMD_FIRST: assert property (
        taken && req.op != PFC_OP_READ |-> ##[1:6] ($fell(flash_we_n)
        && flash_addr == `PFC_UNLOCK_ADDR1
        && flash_data_out == `PFC_UNLOCK_DATA1))
        else $error("Command did not open with first unlock write");
    AST_READ_START: assert property (
        taken && req.op == PFC_OP_READ |-> ##[1:4] $fell(flash_oe_n))
        else $error("Read did not lower output enable");
    AST_RSP_PULSE: assert property (
        rsp_valid |=> !rsp_valid && req_ready && !op_busy)
        else $error("Response not a single pulse into idle");
endmodule

bind pfc_flash_ctrl pfc_flash_ctrl_asserts pfc_flash_ctrl_asserts_inst (
    .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .op_busy(op_busy), .flash_addr(flash_addr),
    .flash_cs_n(flash_cs_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_data_out(flash_data_out),
    .flash_data_oe(flash_data_oe));

// >>> tb/pfc_flash_model.sv
`timescale 1ns/1ps
// Behavioural flash device: self-timed program and erase, status reads
module pfc_flash_model #(
    parameter int         PROG_NS  = 3000,
    parameter int         ERASE_NS = 10000,
    parameter logic [7:0] MFR_ID   = 8'h3C, // Arbitrary value
    parameter logic [7:0] DEV_ID   = 8'hC3  // Arbitrary value
)(
    input  wire logic [17:0] addr,
    input  wire logic        cs_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [7:0]  dq,
    output logic [7:0]       dout,
    output logic             doe
);
    logic [7:0]  mem [int];
    int          kill [$];
    logic [17:0] a_lat, op_a;
    logic [7:0]  ld_data;
    logic [3:0]  step = 4'h0;
    logic        busy = 1'b0, is_prog, locked = 1'b0, id_mode = 1'b0;
    logic        tog = 1'b0;
    realtime     t_fall;
    event        go;
    wire wr_act = !cs_n && !we_n && oe_n;
    wire rd_act = !cs_n && !oe_n && we_n;

    function automatic logic [7:0] rd_mem(logic [17:0] a);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction

    task automatic start_op(logic prog, logic [17:0] a, logic [7:0] d);
        if (prog && locked && a <= 18'h01FFF) return;
        is_prog = prog;
        op_a = a;
        ld_data = d;
        busy = 1'b1;
        -> go;
    endtask

    task automatic decode(logic [17:0] a, logic [7:0] d);
        logic u1, u2;
        u1 = a == 18'h05555;
        u2 = a == 18'h02AAA;
        case (step)
            4'h0: if (u1 && d == 8'hAA) step = 4'h1;
                  else if (d == 8'hF0) id_mode = 1'b0;
            4'h1: step = (u2 && d == 8'h55) ? 4'h2 : 4'h0;
            4'h2: begin
                step = 4'h0;
                if (u1 && d == 8'h80) step = 4'h3;
                else if (u1 && d == 8'hA0) step = 4'h6;
                else if (u1 && d == 8'h90) id_mode = 1'b1;
                else if (u1 && d == 8'hF0) id_mode = 1'b0;
            end
            4'h3: step = (u1 && d == 8'hAA) ? 4'h4 : 4'h0;
            4'h4: step = (u2 && d == 8'h55) ? 4'h5 : 4'h0;
            4'h5: begin
                step = 4'h0;
                if (u1 && d == 8'h10) start_op(1'b0, a, d);
                else if (u1 && d == 8'h40) locked = 1'b1;
            end
            default: begin
                step = 4'h0;
                start_op(1'b1, a, d);
            end
        endcase
    endtask

    assign doe = rd_act;
    always @(posedge rd_act) begin
        tog = !tog;
        if (busy && is_prog) dout = {~ld_data[7], tog, ld_data[5:0]};
        else if (busy) dout = {1'b0, tog, 6'h00};
        else if (id_mode && addr == 18'h00000) dout = MFR_ID;
        else if (id_mode && addr == 18'h00001) dout = DEV_ID;
        else if (id_mode && addr == 18'h00002) dout = {7'h00, locked};
        else dout = rd_mem(addr);
    end
    always @(posedge wr_act) begin
        a_lat = addr;
        t_fall = $realtime;
    end
    always @(negedge wr_act)
        if (!busy && $realtime - t_fall >= 15.0) decode(a_lat, dq);
    always @(go) begin
        #(is_prog ? PROG_NS : ERASE_NS);
        if (is_prog) mem[op_a] = rd_mem(op_a) & ld_data;
        else begin
            foreach (mem[k]) if (!locked || k > 'h1FFF) kill.push_back(k);
            foreach (kill[i]) mem.delete(kill[i]);
            kill.delete();
        end
        busy = 1'b0;
    end
endmodule

// >>> tb/tb_parallel_flash_command_control.sv
`timescale 1ns/1ps
module tb_parallel_flash_command_control;
    import pfc_pkg::*;
    localparam logic [7:0] MFR = 8'h3C; // Arbitrary value
    localparam logic [7:0] DEV = 8'hC3; // Arbitrary value
    logic        core_clk = 1'b0, resetn = 1'b0, req_valid = 1'b0;
    logic        clk_en = 1'b1;
    pfc_req_s    req = '0;
    logic        req_ready, rsp_valid, rsp_timeout, op_busy;
    logic        cs_n, oe_n, we_n, doe, m_doe;
    logic [17:0] addr;
    logic [7:0]  rsp_data, dout, m_dout, dq, dq_hold = 8'h00, q;
    int          n_fail = 0, comparisons = 0;

    always #50 core_clk = ~core_clk;
    // Released bus shows the inverse of its last driven value
    always_comb dq = m_doe ? m_dout : doe ? dout : ~dq_hold;
    always @(posedge core_clk) if (m_doe || doe) dq_hold <= dq;

    pfc_flash_ctrl #(.BP_CYCLES(400), .EC_CYCLES(2000)) pfc_flash_ctrl_inst (
        .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
        .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_timeout(rsp_timeout), .op_busy(op_busy), .flash_addr(addr),
        .flash_cs_n(cs_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .flash_data_in(dq), .flash_data_out(dout), .flash_data_oe(doe));
    pfc_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) pfc_flash_model_inst (
        .addr(addr), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .dq(dq),
        .dout(m_dout), .doe(m_doe));

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic do_op(pfc_op_e op, logic [17:0] a, logic [7:0] d);
        int i;
        @(negedge core_clk);
        req_valid = 1'b1;
        req.op = op;
        req.addr = a;
        req.data = d;
        for (i = 0; req_ready !== 1'b1 && i < 100; i++) @(negedge core_clk);
        if (i >= 100) begin
            n_fail++;
            $display("[ERR] req_ready expected 1 seen 0");
            final_report();
        end
        @(negedge core_clk);
        req_valid = 1'b0;
        for (i = 0; rsp_valid !== 1'b1 && i < 20000; i++)
            @(negedge core_clk);
        if (i >= 20000) begin
            n_fail++;
            $display("[ERR] rsp_valid expected 1 seen 0");
            final_report();
        end
        q = rsp_data;
    endtask

    task automatic t_program();
        do_op(PFC_OP_READ, 18'h3FFFF, 8'h00);
        check("erased_read", q, 8'hFF);
        do_op(PFC_OP_PROGRAM, 18'h12345, 8'h5A);
        check("prog_poll", q, 8'h5A);
        check("prog_flag", {7'h00, rsp_timeout}, 8'h00);
        do_op(PFC_OP_PROGRAM, 18'h12345, 8'h0F);
        do_op(PFC_OP_READ, 18'h12345, 8'h00);
        check("prog_clear", q, 8'h0A);
        do_op(PFC_OP_PROGRAM, 18'h00100, 8'h33);
        do_op(PFC_OP_READ, 18'h00100, 8'h00);
        check("boot_open", q, 8'h33);
        $display("test program done");
    endtask

    task automatic t_ident();
        do_op(PFC_OP_ID_READ, 18'h00002, 8'h00);
        check("lock_clear", q, 8'h00);
        do_op(PFC_OP_ID_READ, 18'h00000, 8'h00);
        check("mfr_code", q, MFR);
        do_op(PFC_OP_ID_READ, 18'h00001, 8'h00);
        check("dev_code", q, DEV);
        do_op(PFC_OP_READ, 18'h00000, 8'h00);
        check("id_left", q, 8'hFF);
        $display("test ident done");
    endtask

    task automatic t_lock();
        do_op(PFC_OP_LOCK, 18'h00000, 8'h00);
        do_op(PFC_OP_ID_READ, 18'h00002, 8'h00);
        check("lock_set", q, 8'h01);
        do_op(PFC_OP_PROGRAM, 18'h01FFF, 8'h00);
        do_op(PFC_OP_READ, 18'h01FFF, 8'h00);
        check("boot_edge", q, 8'hFF);
        do_op(PFC_OP_PROGRAM, 18'h02000, 8'h11);
        do_op(PFC_OP_READ, 18'h02000, 8'h00);
        check("main_edge", q, 8'h11);
        $display("test lock done");
    endtask

    task automatic t_erase();
        do_op(PFC_OP_ERASE, 18'h00000, 8'h00);
        do_op(PFC_OP_READ, 18'h12345, 8'h00);
        check("erase_main", q, 8'hFF);
        do_op(PFC_OP_READ, 18'h02000, 8'h00);
        check("erase_edge", q, 8'hFF);
        do_op(PFC_OP_READ, 18'h00100, 8'h00);
        check("boot_kept", q, 8'h33);
        $display("test erase done");
    endtask

    // Clock enable low must hold off a pending request
    task automatic t_freeze();
        @(negedge core_clk);
        clk_en = 1'b0;
        req_valid = 1'b1;
        req.op = PFC_OP_READ;
        req.addr = 18'h00100;
        repeat (5) @(negedge core_clk);
        check("frozen_busy", {7'h00, op_busy}, 8'h00);
        check("frozen_pins", {5'h00, cs_n, oe_n, we_n}, 8'h07);
        req_valid = 1'b0;
        clk_en = 1'b1;
        do_op(PFC_OP_READ, 18'h00100, 8'h00);
        check("thawed_read", q, 8'h33);
        $display("test freeze done");
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        t_program();
        t_ident();
        t_lock();
        t_erase();
        t_freeze();
        final_report();
    end
endmodule
